// ===== src/rc_calibrator.sv
`timescale 1ns/1ps
`include "sleep_wakeup_timer_defs.svh"
module rc_calibrator
  import sleep_wakeup_timer_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_clk_en,
  input  wire logic       i_start,
  input  wire logic       i_rc_tick,
  input  wire logic       i_xtal_ready,
  output logic            o_xtal_req,
  output logic            o_busy,
  output logic            o_done,
  output logic [7:0]      o_trim
);
  cal_state_t  state_q;
  logic [13:0] ref_cnt_q;
  logic [2:0]  rc_seen_q;

  assign o_busy     = (state_q != CAL_IDLE);
  assign o_xtal_req = o_busy;

  // start crystal, align to an RC edge, count reference cycles over RC ticks
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_q   <= CAL_IDLE;
      ref_cnt_q <= '0;
      rc_seen_q <= '0;
      o_done    <= 1'b0;
      o_trim    <= 8'h00;
    end else if (i_clk_en) begin
      o_done <= 1'b0;
      case (state_q)
        CAL_IDLE: begin
          if (i_start) state_q <= CAL_WAIT_XO;
        end
        CAL_WAIT_XO: begin
          if (i_xtal_ready) state_q <= CAL_ALIGN;
        end
        CAL_ALIGN: begin
          ref_cnt_q <= '0;
          rc_seen_q <= '0;
          if (i_rc_tick) state_q <= CAL_MEASURE;
        end
        CAL_MEASURE: begin
          ref_cnt_q <= ref_cnt_q + 1'b1;
          if (i_rc_tick) rc_seen_q <= rc_seen_q + 1'b1;
          if (i_rc_tick && rc_seen_q == 3'(`CAL_RC_TICKS - 1)) begin
            // slow RC shows extra reference cycles: shorten its period
            if (ref_cnt_q + 1'b1 > 14'(`CAL_EXPECT) && o_trim != 8'h80) begin
              o_trim <= o_trim - 1'b1;
            end else if (ref_cnt_q + 1'b1 < 14'(`CAL_EXPECT) && o_trim != 8'h7F) begin
              o_trim <= o_trim + 1'b1;
            end
            o_done  <= 1'b1;
            state_q <= CAL_IDLE;
          end
        end
        default: state_q <= CAL_IDLE;
      endcase
    end
  end

  a_cal_trim_step: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !$stable(o_trim) |-> o_done)
    else $error("trim changed outside a finished calibration");
endmodule : rc_calibrator

// ===== src/sleep_wakeup_timer.sv
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "sleep_wakeup_timer_defs.svh"
module sleep_wakeup_timer
  import sleep_wakeup_timer_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_clk_en,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  input  wire logic       i_ext_32k,
  input  wire logic       i_power_up_cmd,
  input  wire logic       i_shutdown_exit,
  input  wire logic       i_xtal_ready,
  input  wire logic       i_preamble_ok,
  input  wire logic       i_rx_error,
  input  wire logic       i_packet_done,
  input  wire logic       i_batt_done,
  input  wire logic [7:0] i_batt_level,
  output logic            o_xtal_req,
  output logic [7:0]      o_rc_trim,
  output logic            o_batt_start,
  output logic            o_rx_start,
  output logic            o_rx_stop,
  output logic            o_rx_active,
  output logic            o_go_ready,
  output logic            o_go_sleep,
  output logic            o_expiry_pin,
  output logic            o_irq_out_n
);
  // software visible settings
  logic [7:0] timer_config_q;
  logic [7:0] mant_high_q;
  logic [7:0] mant_low_q;
  logic [7:0] exponent_q;
  logic [7:0] window_count_q;
  logic [2:0] clock_cfg_q;
  logic       top_irq_en_q;
  logic [`EV_COUNT-1:0] chip_irq_en_q;
  logic [`EV_COUNT-1:0] chip_status_q;
  logic [5:0] pin_func_q;
  logic [5:0] irq_pin_func_q;
  logic       rx_start_field_q;
  logic [7:0] batt_thresh_q;

  // timer state
  logic        slow_tick;
  logic        rc_tick;
  logic [33:0] unit_cnt_q;
  logic [15:0] mant_cnt_q;
  logic [15:0] interval_mantissa;
  logic        timer_enable_bit;
  logic        running;
  logic        unit_end;
  logic        expiry;
  rx_state_t   rx_state_q;
  logic [7:0]  win_cnt_q;
  logic        preamble_seen_q;
  logic        rx_end;
  logic [17:0] recal_cnt_q;
  logic        cal_pending_q;
  logic        cal_busy;
  logic        cal_done;
  logic        cal_start;
  logic        recal_due;
  logic        batt_low;
  logic [`EV_COUNT-1:0] ev_set;
  logic        wr_status;
  logic        irq;

  // last prescaler count of one interval unit for a given exponent
  function automatic logic [33:0] unit_last(input logic [4:0] exp_v);
    unit_last = (34'(`UNIT_BASE) << exp_v) - 34'h1;
  endfunction : unit_last

  assign interval_mantissa = {mant_high_q, mant_low_q};
  assign timer_enable_bit  = timer_config_q[`CFG_TIMER_EN];
  assign running           = timer_enable_bit && (interval_mantissa != 16'h0000);

  // configuration writes
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      timer_config_q   <= `REG_RESET;
      mant_high_q      <= `REG_RESET;
      mant_low_q       <= `REG_RESET;
      exponent_q       <= `REG_RESET;
      window_count_q   <= `REG_RESET;
      clock_cfg_q      <= 3'h0;
      top_irq_en_q     <= 1'b0;
      chip_irq_en_q    <= '0;
      pin_func_q       <= 6'h00;
      irq_pin_func_q   <= 6'h00;
      rx_start_field_q <= 1'b0;
      batt_thresh_q    <= `REG_RESET;
    end else if (i_clk_en && i_wr) begin
      case (i_addr)
        `A_TIMER_CONFIG: timer_config_q   <= {1'b0, i_wdata[6:0]};
        `A_MANT_HIGH:    mant_high_q      <= i_wdata;
        `A_MANT_LOW:     mant_low_q       <= i_wdata;
        `A_EXPONENT:     exponent_q       <= {2'b00, i_wdata[5:0]};
        `A_WINDOW_COUNT: window_count_q   <= i_wdata;
        `A_CLOCK_CFG:    clock_cfg_q      <= i_wdata[2:0];
        `A_TOP_IRQ_EN:   top_irq_en_q     <= i_wdata[0];
        `A_CHIP_IRQ_EN:  chip_irq_en_q    <= i_wdata[`EV_COUNT-1:0];
        `A_PIN_FUNC:     pin_func_q       <= i_wdata[5:0];
        `A_IRQ_PIN_FUNC: irq_pin_func_q   <= i_wdata[5:0];
        `A_RX_START:     rx_start_field_q <= i_wdata[0];
        `A_BATT_THRESH:  batt_thresh_q    <= i_wdata;
        default: ;
      endcase
    end
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_clk_en) begin
      o_rdata <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `A_TIMER_CONFIG:    o_rdata <= timer_config_q;
          `A_MANT_HIGH:       o_rdata <= mant_high_q;
          `A_MANT_LOW:        o_rdata <= mant_low_q;
          `A_EXPONENT:        o_rdata <= exponent_q;
          `A_WINDOW_COUNT:    o_rdata <= window_count_q;
          `A_CLOCK_CFG:       o_rdata <= {5'h00, clock_cfg_q};
          `A_TOP_IRQ_EN:      o_rdata <= {7'h00, top_irq_en_q};
          `A_CHIP_IRQ_EN:     o_rdata <= {5'h00, chip_irq_en_q};
          `A_CHIP_IRQ_STATUS: o_rdata <= {5'h00, chip_status_q};
          `A_PIN_FUNC:        o_rdata <= {2'b00, pin_func_q};
          `A_IRQ_PIN_FUNC:    o_rdata <= {2'b00, irq_pin_func_q};
          `A_RX_START:        o_rdata <= {7'h00, rx_start_field_q};
          `A_STATE:           o_rdata <= {4'h0, o_rx_active, cal_busy, running, o_go_sleep};
          `A_BATT_THRESH:     o_rdata <= batt_thresh_q;
          default:            o_rdata <= 8'h00;
        endcase
      end
    end
  end

  slow_tick_gen #(
    .DIV_W (12)
  ) u_tick (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clk_en   (i_clk_en),
    .i_src_sel  (clock_cfg_q),
    .i_ext_32k  (i_ext_32k),
    .i_trim     (o_rc_trim),
    .o_tick     (slow_tick),
    .o_rc_tick  (rc_tick)
  );

  // interval counter: units of 4 * 2^exponent ticks, mantissa units per period
  assign unit_end = slow_tick && (unit_cnt_q >= unit_last(exponent_q[4:0]));
  assign expiry   = running && unit_end && (mant_cnt_q >= interval_mantissa - 16'h1);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      unit_cnt_q <= '0;
      mant_cnt_q <= '0;
    end else if (i_clk_en) begin
      if (!running) begin
        unit_cnt_q <= '0;
        mant_cnt_q <= '0;
      end else if (slow_tick) begin // counts on regardless of sleep
        unit_cnt_q <= unit_end ? '0 : unit_cnt_q + 34'h1;
        if (expiry) begin
          mant_cnt_q <= '0;
        end else if (unit_end) begin
          mant_cnt_q <= mant_cnt_q + 16'h1;
        end
      end
    end
  end

  // duty-cycled receive window, may be extended once after a preamble
  assign rx_end = (rx_state_q != RX_OFF) && (i_packet_done ||
                  (unit_end && win_cnt_q + 8'h1 >= window_count_q &&
                   !(rx_state_q == RX_WINDOW && preamble_seen_q)));

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rx_state_q      <= RX_OFF;
      win_cnt_q       <= 8'h00;
      preamble_seen_q <= 1'b0;
    end else if (i_clk_en) begin
      case (rx_state_q)
        RX_OFF: begin
          win_cnt_q       <= 8'h00;
          preamble_seen_q <= 1'b0;
          if (expiry && (timer_config_q[`CFG_DUTY_EN] || rx_start_field_q)) begin
            rx_state_q <= RX_WINDOW;
          end
        end
        RX_WINDOW, RX_EXTENDED: begin
          // a receive error cancels the extension earned by a preamble
          if (i_rx_error) begin
            preamble_seen_q <= 1'b0;
          end else if (i_preamble_ok) begin
            preamble_seen_q <= 1'b1;
          end
          if (rx_end) begin
            rx_state_q <= RX_OFF;
          end else if (unit_end && win_cnt_q + 8'h1 >= window_count_q) begin
            rx_state_q <= RX_EXTENDED;
            win_cnt_q  <= 8'h00;
          end else if (unit_end) begin
            win_cnt_q <= win_cnt_q + 8'h1;
          end
        end
        default: rx_state_q <= RX_OFF;
      endcase
    end
  end

  // pulses toward the radio and the power sequencer
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rx_start   <= 1'b0;
      o_rx_stop    <= 1'b0;
      o_go_ready   <= 1'b0;
      o_go_sleep   <= 1'b0;
      o_batt_start <= 1'b0;
    end else if (i_clk_en) begin
      o_rx_start   <= (rx_state_q == RX_OFF) && expiry &&
                      (timer_config_q[`CFG_DUTY_EN] || rx_start_field_q);
      o_rx_stop    <= rx_end;
      o_go_ready   <= (rx_end || (expiry && !timer_config_q[`CFG_DUTY_EN] &&
                      !rx_start_field_q)) && !exponent_q[`EXP_SLEEP_BIT];
      o_go_sleep   <= (rx_end || (expiry && !timer_config_q[`CFG_DUTY_EN] &&
                      !rx_start_field_q)) && exponent_q[`EXP_SLEEP_BIT];
      o_batt_start <= expiry && timer_config_q[`CFG_BATT_EN];
    end
  end

  assign o_rx_active = (rx_state_q != RX_OFF);

  // calibration requests: power-up, shutdown exit and the periodic counter
  // shift amount kept five bits wide so the base exponent is not cut
  assign recal_due = timer_config_q[`CFG_CAL_EN] && slow_tick &&
                     (recal_cnt_q >= (18'h1 << (5'(timer_config_q[6:4]) +
                                                5'(`RECAL_BASE_LOG))) - 18'h1);
  assign cal_start = cal_pending_q && !cal_busy;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      recal_cnt_q   <= '0;
      cal_pending_q <= 1'b1;
    end else if (i_clk_en) begin
      if (!timer_config_q[`CFG_CAL_EN] || recal_due) begin
        recal_cnt_q <= '0;
      end else if (slow_tick) begin
        recal_cnt_q <= recal_cnt_q + 18'h1;
      end
      if (i_power_up_cmd || i_shutdown_exit || recal_due) begin
        cal_pending_q <= 1'b1;
      end else if (cal_start) begin
        cal_pending_q <= 1'b0;
      end
    end
  end

  rc_calibrator u_cal (
    .i_core_clk   (i_core_clk),
    .i_reset      (i_reset),
    .i_clk_en     (i_clk_en),
    .i_start      (cal_start),
    .i_rc_tick    (rc_tick),
    .i_xtal_ready (i_xtal_ready),
    .o_xtal_req   (o_xtal_req),
    .o_busy       (cal_busy),
    .o_done       (cal_done),
    .o_trim       (o_rc_trim)
  );

  // sticky chip status, write one to clear, a new event beats the clear
  assign batt_low         = i_batt_done && (i_batt_level < batt_thresh_q);
  assign ev_set[`EV_EXPIRY]   = expiry;
  assign ev_set[`EV_BATT_LOW] = batt_low;
  assign ev_set[`EV_CAL_DONE] = cal_done;
  assign wr_status        = i_wr && (i_addr == `A_CHIP_IRQ_STATUS);

  genvar gi;
  generate
    for (gi = 0; gi < `EV_COUNT; gi++) begin : g_status
      always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
          chip_status_q[gi] <= 1'b0;
        end else if (i_clk_en) begin
          if (ev_set[gi]) begin
            chip_status_q[gi] <= 1'b1;
          end else if (wr_status && i_wdata[gi]) begin
            chip_status_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // interrupt needs the top-level and per-event enables
  assign irq          = top_irq_en_q && |(chip_status_q & chip_irq_en_q);
  assign o_irq_out_n  = ~irq;
  assign o_expiry_pin = (pin_func_q == `EXPIRY_PIN_CODE) &&
                        (irq_pin_func_q == `EXPIRY_IRQ_CODE) &&
                        chip_status_q[`EV_EXPIRY];

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  a_irq_needs_enables: assert property (!o_irq_out_n |-> top_irq_en_q)
    else $error("interrupt without top-level enable");
  a_expiry_sets_irq: assert property (
    (i_clk_en && expiry && top_irq_en_q && chip_irq_en_q[`EV_EXPIRY] && !i_wr) |=> !o_irq_out_n)
    else $error("enabled expiry did not raise interrupt");
  a_timer_reload: assert property (expiry && i_clk_en |=> mant_cnt_q == 16'h0000)
    else $error("timer did not reload after expiry");
  a_batt_per_expiry: assert property (
    (i_clk_en && expiry) |=> (o_batt_start == $past(timer_config_q[`CFG_BATT_EN])))
    else $error("battery measurement not matched to expiry");
  a_rx_on_wake: assert property (
    (i_clk_en && expiry && rx_state_q == RX_OFF && timer_config_q[`CFG_DUTY_EN])
    |=> o_rx_start ##1 o_rx_active)
    else $error("duty-cycle wake did not start receive");
  a_no_rx_disabled: assert property (
    o_rx_start |-> $past(timer_config_q[`CFG_DUTY_EN] || rx_start_field_q))
    else $error("receive started while duty cycle and start field off");
  a_end_state_sel: assert property (
    o_go_sleep |-> !o_go_ready && $past(exponent_q[`EXP_SLEEP_BIT]))
    else $error("wrong end state after expiry");
  a_window_closes: assert property (
    (i_clk_en && rx_end) |=> rx_state_q == RX_OFF ##1 $stable(rx_state_q) || o_rx_start)
    else $error("receive window did not close");
  a_powerup_cal: assert property ($fell(i_reset) |-> ##[1:3] cal_busy)
    else $error("no calibration after power-up");
  a_pin_code: assert property (o_expiry_pin |-> pin_func_q == 6'h0E)
    else $error("expiry pin active under wrong pin code");
  a_status_sticky: assert property (
    (chip_status_q[`EV_EXPIRY] && !wr_status) |=> chip_status_q[`EV_EXPIRY])
    else $error("expiry status lost without clear");

  c_expiry:    cover property (expiry);
  c_rx_extend: cover property (rx_state_q == RX_EXTENDED);
  c_cal_done:  cover property (cal_done);
  c_batt_low:  cover property (batt_low);
endmodule : sleep_wakeup_timer

// ===== src/sleep_wakeup_timer_defs.svh
`ifndef SLEEP_WAKEUP_TIMER_DEFS_SVH
`define SLEEP_WAKEUP_TIMER_DEFS_SVH

// register offsets
`define A_TIMER_CONFIG     4'h0
`define A_MANT_HIGH        4'h1
`define A_MANT_LOW         4'h2
`define A_EXPONENT         4'h3
`define A_WINDOW_COUNT     4'h4
`define A_CLOCK_CFG        4'h5
`define A_TOP_IRQ_EN       4'h6
`define A_CHIP_IRQ_EN      4'h7
`define A_CHIP_IRQ_STATUS  4'h8
`define A_PIN_FUNC         4'h9
`define A_IRQ_PIN_FUNC     4'hA
`define A_RX_START         4'hB
`define A_STATE            4'hC
`define A_BATT_THRESH      4'hD

// timer_config fields
`define CFG_TIMER_EN       0
`define CFG_BATT_EN        1
`define CFG_DUTY_EN        2
`define CFG_CAL_EN         3
`define CFG_CAL_SEL_LO     4
// exponent register: end-state bit
`define EXP_SLEEP_BIT      5
// chip status event bits
`define EV_EXPIRY          0
`define EV_BATT_LOW        1
`define EV_CAL_DONE        2
`define EV_COUNT           3

`define REG_RESET          8'h00
`define SRC_XTAL           3'h1
`define EXPIRY_PIN_CODE    6'h0E
`define EXPIRY_IRQ_CODE    6'h27

// timing
`define CORE_HZ            20000000
`define SLOW_HZ            32768
`define RC_DIV             (`CORE_HZ / `SLOW_HZ)
`define UNIT_BASE          4
`define CAL_RC_TICKS       4
`define CAL_EXPECT         (`CAL_RC_TICKS * `RC_DIV)
`define RECAL_BASE_LOG     10

`endif

// ===== src/sleep_wakeup_timer_pkg.sv
package sleep_wakeup_timer_pkg;
  typedef enum logic [1:0] {RX_OFF, RX_WINDOW, RX_EXTENDED} rx_state_t;
  typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT_XO, CAL_ALIGN, CAL_MEASURE} cal_state_t;
endpackage : sleep_wakeup_timer_pkg

// ===== src/slow_tick_gen.sv
`timescale 1ns/1ps
`include "sleep_wakeup_timer_defs.svh"
module slow_tick_gen #(
  parameter int DIV_W = 12
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_clk_en,
  input  wire logic [2:0] i_src_sel,
  input  wire logic       i_ext_32k,
  input  wire logic [7:0] i_trim,
  output logic            o_tick,
  output logic            o_rc_tick
);
  logic [DIV_W-1:0] rc_cnt_q;
  logic [DIV_W-1:0] rc_last;
  logic             ext_q;
  logic             rc_hit;

  // trimmed divider models the internal RC oscillator
  assign rc_last = DIV_W'(`RC_DIV - 1) + {{(DIV_W-8){i_trim[7]}}, i_trim};
  assign rc_hit  = (rc_cnt_q >= rc_last);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rc_cnt_q <= '0;
    end else if (i_clk_en) begin
      rc_cnt_q <= rc_hit ? '0 : rc_cnt_q + 1'b1;
    end
  end

  // rising edge of the external crystal clock, selected by source code
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ext_q     <= 1'b0;
      o_tick    <= 1'b0;
      o_rc_tick <= 1'b0;
    end else if (i_clk_en) begin
      ext_q     <= i_ext_32k;
      o_rc_tick <= rc_hit;
      o_tick    <= (i_src_sel == `SRC_XTAL) ? (i_ext_32k & ~ext_q) : rc_hit;
    end
  end
endmodule : slow_tick_gen

// ===== verif/radio_env_model.sv
`timescale 1ns/1ps
module radio_env_model #(
  parameter int EXT_HALF_NS = 15258, // near 32768 Hz, edges never on a core rising edge
  parameter int XO_START    = 20
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_xtal_req,
  input  wire logic       i_batt_start,
  input  wire logic [7:0] i_batt_value,
  output logic            o_xtal_ready,
  output logic            o_batt_done,
  output logic [7:0]      o_batt_level,
  output logic            o_ext_32k
);
  int xo_cnt;
  int adc_cnt;
  // free-running low-frequency crystal, edges kept off the core rising edge
  initial begin
    o_ext_32k = 1'b0;
    forever #(EXT_HALF_NS) o_ext_32k = ~o_ext_32k;
  end
  // main crystal reports stable a while after it is requested
  always @(posedge i_core_clk) begin
    xo_cnt <= i_xtal_req ? xo_cnt + 1 : 0;
    o_xtal_ready <= i_xtal_req && xo_cnt >= XO_START;
  end
  // one conversion per start pulse; level is garbage outside the result cycle
  always @(posedge i_core_clk) begin
    adc_cnt <= i_batt_start ? 6 : (adc_cnt > 0 ? adc_cnt - 1 : 0);
    o_batt_done <= adc_cnt == 1;
    o_batt_level <= adc_cnt == 1 ? i_batt_value : ~i_batt_value;
  end
endmodule : radio_env_model

// ===== verif/tb_sleep_wakeup_timer.sv
`timescale 1ns/1ps
module tb_sleep_wakeup_timer;
  logic       i_core_clk, i_reset, i_wr, i_rd, i_power_up_cmd, i_shutdown_exit;
  logic       i_packet_done, i_ext_32k, i_xtal_ready, i_batt_done, o_xtal_req;
  logic       o_batt_start, o_rx_start, o_rx_stop, o_rx_active, o_go_ready, o_go_sleep;
  logic       o_expiry_pin, o_irq_out_n, i_preamble_ok, i_clk_en;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, o_rc_trim, i_batt_level, batt_value, d;
  int         err_count, comparisons, cycles, took;

  sleep_wakeup_timer i_sleep_wakeup_timer (.i_core_clk, .i_reset, .i_clk_en, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_ext_32k, .i_power_up_cmd, .i_shutdown_exit,
    .i_xtal_ready, .i_preamble_ok, .i_rx_error(1'b0), .i_packet_done, .i_batt_done,
    .i_batt_level, .o_xtal_req, .o_rc_trim, .o_batt_start, .o_rx_start, .o_rx_stop,
    .o_rx_active, .o_go_ready, .o_go_sleep, .o_expiry_pin, .o_irq_out_n);
  radio_env_model i_radio_env_model (.i_core_clk, .i_xtal_req(o_xtal_req),
    .i_batt_start(o_batt_start), .i_batt_value(batt_value), .o_xtal_ready(i_xtal_ready),
    .o_batt_done(i_batt_done), .o_batt_level(i_batt_level), .o_ext_32k(i_ext_32k));

  task automatic chk(string s, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", s, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(logic [3:0] a);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  function automatic logic pick(int k);
    case (k)
      0: return o_go_ready;
      1: return o_go_sleep;
      2: return o_rx_start;
      3: return o_rx_stop;
      4: return o_batt_start;
      5: return o_xtal_req;
      6: return !o_xtal_req;
      default: return i_batt_done;
    endcase
  endfunction : pick
  // bounded wait; took holds the cycles spent
  task automatic waitk(int k, int lim);
    took = 0;
    do begin
      @(posedge i_core_clk);
      #1 took++;
    end while (pick(k) !== 1'b1 && took < lim);
    chk("wait", took < lim, 1'b1);
  endtask : waitk

  task automatic t_regs;
    logic [3:0] a [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB,
                           4'hD, 4'hE};
    logic [7:0] m [13] = '{8'h7F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'h07, 8'h01, 8'h07, 8'h3F,
                           8'h3F, 8'h01, 8'hFF, 8'h00};
    for (int i = 0; i < 13; i++) begin
      rd(a[i]);
      chk("reset value", d, 8'h00);
      wr(a[i], 8'hFF);
      rd(a[i]);
      chk("readback", d, m[i]);
      wr(a[i], 8'h00);
    end
  endtask : t_regs
  task automatic t_expiry;
    wr(4'h2, 8'h01);
    wr(4'h7, 8'h01);
    wr(4'h9, 8'h0E);
    wr(4'hA, 8'h27);
    wr(4'h8, 8'h07);
    wr(4'h0, 8'h01);
    waitk(0, 6000);
    waitk(0, 6000);
    chk("period", took inside {[2400:2480]}, 1'b1);
    chk("irq without top enable", o_irq_out_n, 1'b1);
    rd(4'h8);
    chk("expiry status", d[0], 1'b1);
    chk("expiry pin", o_expiry_pin, 1'b1);
    wr(4'h6, 8'h01);
    #1 chk("irq both enables", o_irq_out_n, 1'b0);
    wr(4'h9, 8'h0D);
    #1 chk("pin code off", o_expiry_pin, 1'b0);
    wr(4'h0, 8'h00);
    wr(4'h8, 8'h01);
    #1 chk("irq cleared", o_irq_out_n, 1'b1);
  endtask : t_expiry
  task automatic t_sleep;
    wr(4'h3, 8'h21);
    wr(4'h0, 8'h01);
    waitk(1, 8000);
    waitk(1, 8000);
    chk("doubled period", took inside {[4800:4960]}, 1'b1);
    batt_value = 8'h40;
    wr(4'hD, 8'h80);
    wr(4'h8, 8'h07);
    wr(4'h0, 8'h03);
    waitk(4, 8000);
    chk("sleep beside check", o_go_sleep, 1'b1);
    waitk(7, 20);
    rd(4'h8);
    chk("battery low", d[1], 1'b1);
    wr(4'h0, 8'h00);
  endtask : t_sleep
  task automatic t_duty;
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h01);
    wr(4'hB, 8'h01);
    wr(4'h0, 8'h05);
    waitk(2, 6000);
    chk("no end state at wake", o_go_ready, 1'b0);
    waitk(3, 3000);
    chk("window", took inside {[2400:2480]}, 1'b1);
    chk("end state at close", o_go_ready, 1'b1);
    waitk(2, 3000);
    @(posedge i_core_clk);
    i_packet_done <= 1'b1;
    waitk(3, 4);
    i_packet_done <= 1'b0;
    #1 chk("window closed", o_rx_active, 1'b0);
    // a preamble in the first window buys one more window
    waitk(2, 3000);
    i_preamble_ok <= 1'b1;
    waitk(3, 6000);
    i_preamble_ok <= 1'b0;
    chk("extended window", took inside {[4800:4960]}, 1'b1);
    wr(4'h0, 8'h00);
    wr(4'hB, 8'h00);
  endtask : t_duty
  task automatic t_ext;
    wr(4'h5, 8'h01);
    wr(4'h0, 8'h01);
    waitk(0, 4000);
    waitk(0, 4000);
    chk("crystal period", took inside {[2441:2442]}, 1'b1);
    wr(4'h0, 8'h00);
  endtask : t_ext
  // with the clock enable low a write must leave no trace
  task automatic t_freeze;
    @(posedge i_core_clk);
    i_clk_en <= 1'b0;
    wr(4'h1, 8'h5A);
    @(posedge i_core_clk);
    i_clk_en <= 1'b1;
    rd(4'h1);
    chk("frozen write", d, 8'h00);
  endtask : t_freeze
  task automatic t_cal(bit shut);
    wr(4'h8, 8'h07);
    @(posedge i_core_clk);
    i_power_up_cmd <= !shut;
    i_shutdown_exit <= shut;
    @(posedge i_core_clk);
    i_power_up_cmd <= 1'b0;
    i_shutdown_exit <= 1'b0;
    waitk(5, 4);
    waitk(6, 6000);
    rd(4'h8);
    chk("calibration done", d[2], 1'b1);
    chk("trim", o_rc_trim inside {8'h00, 8'h01, 8'hFF}, 1'b1);
  endtask : t_cal

  task automatic give_verdict;
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  // run ceiling well above the expected length of all scenarios
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 100000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    {i_wr, i_rd, i_power_up_cmd, i_shutdown_exit, i_packet_done, i_preamble_ok} = '0;
    i_clk_en = 1'b1;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    batt_value = 8'h00;
    i_reset = 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_reset <= 1'b0;
    t_regs();
    t_expiry();
    t_sleep();
    t_duty();
    t_ext();
    t_freeze();
    t_cal(1'b0);
    t_cal(1'b1);
    give_verdict();
  end
endmodule : tb_sleep_wakeup_timer
